// *** core/rail_irq_mask_and_load_meter.sv ***
`timescale 1ns/10ps
`default_nettype none

module rail_irq_mask_and_load_meter #(
   parameter logic [6:0] TARGET_ADDR = 7'h60,
   parameter int         RAILS       = 4
) (
   // clock and reset
   input  wire logic                                   mclk,
   input  wire logic                                   rstn,
   // serial register port
   input  wire logic                                   scl_i,
   input  wire logic                                   sda_i,
   output logic                                        sda_o,
   output logic                                        sda_oe,
   // live rail conditions from the converter cores
   input  wire logic [RAILS-1:0]                       rail_good_raw,
   input  wire logic [RAILS-1:0]                       rail_overcurrent_raw,
   // load current converter
   output logic                                        meas_start,
   output logic [rail_meter_pkg::RAIL_SELECT_WIDTH-1:0] meas_rail,
   input  wire logic                                   meas_done,
   input  wire logic [rail_meter_pkg::RESULT_WIDTH-1:0] meas_value,
   // interrupt, active low
   output logic                                        irq_n
);

   // ********************************
   // declarations
   // ********************************
   logic [7:0]       reg_ptr;
   logic [7:0]       reg_rdata;
   logic             reg_wr;
   logic [7:0]       reg_waddr;
   logic [7:0]       reg_wdata;

   logic [RAILS-1:0] good_meta_q;
   logic [RAILS-1:0] good_sync_q;
   logic [RAILS-1:0] good_prev_q;
   logic [RAILS-1:0] oc_meta_q;
   logic [RAILS-1:0] oc_sync_q;
   logic [RAILS-1:0] oc_prev_q;

   logic [RAILS-1:0] good_irq_block_q;
   logic [RAILS-1:0] oc_irq_block_q;
   logic [RAILS-1:0] good_event_q;
   logic [RAILS-1:0] good_event_d;
   logic [RAILS-1:0] oc_event_q;
   logic [RAILS-1:0] oc_event_d;
   logic             ready_mask_q;
   logic             ready_flag_q;
   logic             ready_flag_d;
   logic [1:0]       rail_select_q;
   logic             meas_start_q;
   logic [9:0]       result_q;
   logic             irq_n_q;

   // ********************************
   // helpers
   // ********************************
   function automatic logic [7:0] pack_pair(input logic hi_good, input logic hi_oc,
                                            input logic lo_good, input logic lo_oc);
      logic [7:0] b;
      b = 8'h00;
      b[rail_meter_pkg::HI_GOOD_BIT]        = hi_good;
      b[rail_meter_pkg::HI_OVERCURRENT_BIT] = hi_oc;
      b[rail_meter_pkg::LO_GOOD_BIT]        = lo_good;
      b[rail_meter_pkg::LO_OVERCURRENT_BIT] = lo_oc;
      return b;
   endfunction

   function automatic logic [3:0] w1c_pair(input logic wr, input logic [7:0] data);
      logic [3:0] c;
      c = 4'h0;
      if (wr)
      begin
         c = {data[rail_meter_pkg::HI_GOOD_BIT], data[rail_meter_pkg::HI_OVERCURRENT_BIT],
              data[rail_meter_pkg::LO_GOOD_BIT], data[rail_meter_pkg::LO_OVERCURRENT_BIT]};
      end
      return c;
   endfunction

   // ********************************
   // serial engine
   // ********************************
   serial_target #(
      .TARGET_ADDR (TARGET_ADDR)
   ) u_serial (
      .mclk      (mclk),
      .rstn      (rstn),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .sda_o     (sda_o),
      .sda_oe    (sda_oe),
      .reg_ptr   (reg_ptr),
      .reg_rdata (reg_rdata),
      .reg_wr    (reg_wr),
      .reg_waddr (reg_waddr),
      .reg_wdata (reg_wdata)
   );

   // ********************************
   // raw condition synchronisers
   // ********************************
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         good_meta_q <= '0;
         good_sync_q <= '0;
         good_prev_q <= '0;
         oc_meta_q   <= '0;
         oc_sync_q   <= '0;
         oc_prev_q   <= '0;
      end
      else
      begin
         good_meta_q <= rail_good_raw;
         good_sync_q <= good_meta_q;
         good_prev_q <= good_sync_q;
         oc_meta_q   <= rail_overcurrent_raw;
         oc_sync_q   <= oc_meta_q;
         oc_prev_q   <= oc_sync_q;
      end
   end

   wire [RAILS-1:0] good_rise = good_sync_q & ~good_prev_q;
   wire [RAILS-1:0] oc_rise   = oc_sync_q & ~oc_prev_q;

   // ********************************
   // write decode
   // ********************************
   wire wr_top_flags = reg_wr && (reg_waddr == rail_meter_pkg::LOAD_READY_FLAGS_ADDR);
   wire wr_ev01      = reg_wr && (reg_waddr == rail_meter_pkg::RAIL01_EVENT_ADDR);
   wire wr_ev23      = reg_wr && (reg_waddr == rail_meter_pkg::RAIL23_EVENT_ADDR);
   wire wr_top_mask  = reg_wr && (reg_waddr == rail_meter_pkg::LOAD_READY_MASK_ADDR);
   wire wr_mask01    = reg_wr && (reg_waddr == rail_meter_pkg::RAIL01_IRQ_MASK_ADDR);
   wire wr_mask23    = reg_wr && (reg_waddr == rail_meter_pkg::RAIL23_IRQ_MASK_ADDR);
   wire wr_select    = reg_wr && (reg_waddr == rail_meter_pkg::LOAD_METER_SELECT_ADDR);

   wire [3:0] clr01 = w1c_pair(wr_ev01, reg_wdata);
   wire [3:0] clr23 = w1c_pair(wr_ev23, reg_wdata);
   wire [RAILS-1:0] good_clr = {clr23[3], clr23[1], clr01[3], clr01[1]};
   wire [RAILS-1:0] oc_clr   = {clr23[2], clr23[0], clr01[2], clr01[0]};

   // an edge in the clearing cycle survives: set wins
   assign good_event_d = (good_event_q & ~good_clr) | good_rise;
   assign oc_event_d   = (oc_event_q & ~oc_clr) | oc_rise;
   assign ready_flag_d = (ready_flag_q
                          & ~(wr_top_flags & reg_wdata[rail_meter_pkg::LOAD_READY_BIT]))
                         | meas_done;

   // ********************************
   // latched event flags
   // ********************************
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         good_event_q <= '0;
         oc_event_q   <= '0;
         ready_flag_q <= 1'b0;
      end
      else
      begin
         good_event_q <= good_event_d;
         oc_event_q   <= oc_event_d;
         ready_flag_q <= ready_flag_d;
      end
   end

   // ********************************
   // interrupt mask registers
   // ********************************
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         good_irq_block_q <= rail_meter_pkg::IRQ_BLOCK_RESET;
         oc_irq_block_q   <= rail_meter_pkg::IRQ_BLOCK_RESET;
         ready_mask_q     <= rail_meter_pkg::LOAD_READY_MASK_RESET;
      end
      else
      begin
         if (wr_mask01)
         begin
            good_irq_block_q[0] <= reg_wdata[rail_meter_pkg::LO_GOOD_BIT];
            oc_irq_block_q[0]   <= reg_wdata[rail_meter_pkg::LO_OVERCURRENT_BIT];
            good_irq_block_q[1] <= reg_wdata[rail_meter_pkg::HI_GOOD_BIT];
            oc_irq_block_q[1]   <= reg_wdata[rail_meter_pkg::HI_OVERCURRENT_BIT];
         end
         if (wr_mask23)
         begin
            good_irq_block_q[3] <= reg_wdata[rail_meter_pkg::HI_GOOD_BIT];
            oc_irq_block_q[3]   <= reg_wdata[rail_meter_pkg::HI_OVERCURRENT_BIT];
            good_irq_block_q[2] <= reg_wdata[rail_meter_pkg::LO_GOOD_BIT];
            oc_irq_block_q[2]   <= reg_wdata[rail_meter_pkg::LO_OVERCURRENT_BIT];
         end
         if (wr_top_mask)
         begin
            ready_mask_q <= reg_wdata[rail_meter_pkg::LOAD_READY_BIT];
         end
      end
   end

   // ********************************
   // load current measurement
   // ********************************
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         rail_select_q <= rail_meter_pkg::RAIL_SELECT_RESET;
         meas_start_q  <= 1'b0;
         result_q      <= rail_meter_pkg::RESULT_RESET;
      end
      else
      begin
         meas_start_q <= wr_select;
         if (wr_select)
         begin
            rail_select_q <= reg_wdata[rail_meter_pkg::RAIL_SELECT_WIDTH-1:0];
         end
         if (meas_done)
         begin
            // kept as the raw 20 mA step count, no scaling in hardware
            result_q <= meas_value;
         end
      end
   end

   assign meas_start = meas_start_q;
   assign meas_rail  = rail_select_q;

   // ********************************
   // interrupt output
   // ********************************
   wire irq_any = |(good_event_q & ~good_irq_block_q)
                | |(oc_event_q & ~oc_irq_block_q)
                | (ready_flag_q & ~ready_mask_q);

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         irq_n_q <= 1'b1;
      end
      else
      begin
         irq_n_q <= ~irq_any;
      end
   end

   assign irq_n = irq_n_q;

   // ********************************
   // read mux
   // ********************************
   wire [7:0] rd_ev01   = pack_pair(good_event_q[1], oc_event_q[1],
                                    good_event_q[0], oc_event_q[0]);
   wire [7:0] rd_ev23   = pack_pair(good_event_q[3], oc_event_q[3],
                                    good_event_q[2], oc_event_q[2]);
   // raw status ignores masks entirely
   wire [7:0] rd_raw01  = pack_pair(good_sync_q[1], oc_sync_q[1],
                                    good_sync_q[0], oc_sync_q[0]);
   wire [7:0] rd_raw23  = pack_pair(good_sync_q[3], oc_sync_q[3],
                                    good_sync_q[2], oc_sync_q[2]);
   wire [7:0] rd_mask01 = pack_pair(good_irq_block_q[1], oc_irq_block_q[1],
                                    good_irq_block_q[0], oc_irq_block_q[0]);
   wire [7:0] rd_mask23 = pack_pair(good_irq_block_q[3], oc_irq_block_q[3],
                                    good_irq_block_q[2], oc_irq_block_q[2]);
   wire [7:0] rd_res_hi = {6'h00, result_q[9:8]};
   wire [7:0] rd_res_lo = result_q[7:0];

   // unused and reserved positions read zero
   assign reg_rdata =
      (reg_ptr == rail_meter_pkg::LOAD_READY_FLAGS_ADDR)  ? {7'h00, ready_flag_q} :
      (reg_ptr == rail_meter_pkg::RAIL01_EVENT_ADDR)      ? rd_ev01 :
      (reg_ptr == rail_meter_pkg::RAIL23_EVENT_ADDR)      ? rd_ev23 :
      (reg_ptr == rail_meter_pkg::RAIL01_RAW_ADDR)        ? rd_raw01 :
      (reg_ptr == rail_meter_pkg::RAIL23_RAW_ADDR)        ? rd_raw23 :
      (reg_ptr == rail_meter_pkg::LOAD_READY_MASK_ADDR)   ? {7'h00, ready_mask_q} :
      (reg_ptr == rail_meter_pkg::RAIL01_IRQ_MASK_ADDR)   ? rd_mask01 :
      (reg_ptr == rail_meter_pkg::RAIL23_IRQ_MASK_ADDR)   ? rd_mask23 :
      (reg_ptr == rail_meter_pkg::LOAD_METER_SELECT_ADDR) ? {6'h00, rail_select_q} :
      (reg_ptr == rail_meter_pkg::LOAD_RESULT_HIGH_ADDR)  ? rd_res_hi :
      (reg_ptr == rail_meter_pkg::LOAD_RESULT_LOW_ADDR)   ? rd_res_lo :
      8'h00;

endmodule

`default_nettype wire

// *** core/rail_meter_pkg.sv ***
package rail_meter_pkg;

   // ********************************
   // register offsets
   // ********************************
   localparam logic [7:0] LOAD_READY_FLAGS_ADDR = 8'h18;
   localparam logic [7:0] RAIL01_EVENT_ADDR     = 8'h19;
   localparam logic [7:0] RAIL23_EVENT_ADDR     = 8'h1A;
   localparam logic [7:0] RAIL01_RAW_ADDR       = 8'h1C;
   localparam logic [7:0] RAIL23_RAW_ADDR       = 8'h1D;
   localparam logic [7:0] LOAD_READY_MASK_ADDR  = 8'h1E;
   localparam logic [7:0] RAIL01_IRQ_MASK_ADDR  = 8'h1F;
   localparam logic [7:0] RAIL23_IRQ_MASK_ADDR  = 8'h20;
   localparam logic [7:0] LOAD_METER_SELECT_ADDR = 8'h21;
   localparam logic [7:0] LOAD_RESULT_HIGH_ADDR = 8'h22;
   localparam logic [7:0] LOAD_RESULT_LOW_ADDR  = 8'h23;

   // ********************************
   // field positions inside a rail pair byte, the load ready bit and field widths
   // ********************************
   localparam int LO_OVERCURRENT_BIT = 0;
   localparam int LO_GOOD_BIT        = 2;
   localparam int HI_OVERCURRENT_BIT = 4;
   localparam int HI_GOOD_BIT        = 6;
   localparam int LOAD_READY_BIT     = 0;
   localparam int RAIL_SELECT_WIDTH  = 2;
   localparam int RESULT_WIDTH       = 10;
   localparam int RESULT_HIGH_WIDTH  = 2;

   // ********************************
   // values after reset
   // ********************************
   localparam logic [3:0] IRQ_BLOCK_RESET      = 4'hF;
   localparam logic       LOAD_READY_MASK_RESET = 1'b0;
   localparam logic [1:0] RAIL_SELECT_RESET    = 2'h0;
   localparam logic [9:0] RESULT_RESET         = 10'h000;

   // ********************************
   // result scaling
   // ********************************
   localparam int RESULT_LSB_MA   = 20;
   localparam int RESULT_FULL_MA  = 20000;

endpackage

// *** core/serial_target.sv ***
`timescale 1ns/10ps
`default_nettype none

module serial_target #(
   parameter logic [6:0] TARGET_ADDR = 7'h60
) (
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rstn,
   // serial pins
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   // register side
   output logic [7:0]      reg_ptr,
   input  wire logic [7:0] reg_rdata,
   output logic            reg_wr,
   output logic [7:0]      reg_waddr,
   output logic [7:0]      reg_wdata
);

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_DEV   = 3'b001,
      ST_DACK  = 3'b011,
      ST_WBYTE = 3'b010,
      ST_WACK  = 3'b110,
      ST_RBYTE = 3'b111,
      ST_RACK  = 3'b101
   } serial_state_type;

   serial_state_type state_q;
   logic [2:0] scl_q;
   logic [2:0] sda_q;
   logic [7:0] shift_q;
   logic [3:0] cnt_q;
   logic       rw_q;
   logic       first_q;
   logic       oe_q;
   logic [7:0] ptr_q;
   logic       wr_q;
   logic [7:0] waddr_q;
   logic [7:0] wdata_q;

   // ********************************
   // pin sampling, stage 0 feeds only stage 1
   // ********************************
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         scl_q <= 3'h7;
         sda_q <= 3'h7;
      end
      else
      begin
         scl_q <= {scl_q[1:0], scl_i};
         sda_q <= {sda_q[1:0], sda_i};
      end
   end

   wire scl_rise   = scl_q[1] & ~scl_q[2];
   wire scl_fall   = ~scl_q[1] & scl_q[2];
   wire start_seen = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
   wire stop_seen  = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
   wire byte_full  = (cnt_q == 4'h8);
   wire addr_hit   = (shift_q[7:1] == TARGET_ADDR);

   // ********************************
   // protocol engine
   // ********************************
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_q <= ST_IDLE;
         shift_q <= 8'h00;
         cnt_q   <= 4'h0;
         rw_q    <= 1'b0;
         first_q <= 1'b0;
         oe_q    <= 1'b0;
         ptr_q   <= 8'h00;
         wr_q    <= 1'b0;
         waddr_q <= 8'h00;
         wdata_q <= 8'h00;
      end
      else
      begin
         wr_q <= 1'b0;
         if (start_seen)
         begin
            state_q <= ST_DEV;
            cnt_q   <= 4'h0;
            first_q <= 1'b1;
            oe_q    <= 1'b0;
         end
         else if (stop_seen)
         begin
            state_q <= ST_IDLE;
            oe_q    <= 1'b0;
         end
         else if (scl_rise)
         begin
            if (state_q == ST_DEV || state_q == ST_WBYTE)
            begin
               shift_q <= {shift_q[6:0], sda_q[1]};
               cnt_q   <= cnt_q + 4'h1;
            end
            else if (state_q == ST_RACK)
            begin
               rw_q <= ~sda_q[1];
            end
         end
         else if (scl_fall)
         begin
            case (state_q)
               ST_DEV:
               begin
                  if (byte_full)
                  begin
                     state_q <= addr_hit ? ST_DACK : ST_IDLE;
                     oe_q    <= addr_hit;
                     rw_q    <= shift_q[0];
                  end
               end
               ST_DACK, ST_RACK:
               begin
                  cnt_q <= (rw_q ? 4'h1 : 4'h0);
                  if (rw_q)
                  begin
                     // next byte fetched at the pointer, pointer then advances
                     state_q <= ST_RBYTE;
                     shift_q <= reg_rdata;
                     oe_q    <= ~reg_rdata[7];
                     ptr_q   <= ptr_q + 8'h01;
                  end
                  else
                  begin
                     state_q <= (state_q == ST_DACK) ? ST_WBYTE : ST_IDLE;
                     oe_q    <= 1'b0;
                  end
               end
               ST_WBYTE:
               begin
                  if (byte_full)
                  begin
                     state_q <= ST_WACK;
                     oe_q    <= 1'b1;
                     first_q <= 1'b0;
                     if (first_q)
                     begin
                        ptr_q <= shift_q;
                     end
                     else
                     begin
                        wr_q    <= 1'b1;
                        waddr_q <= ptr_q;
                        wdata_q <= shift_q;
                        ptr_q   <= ptr_q + 8'h01;
                     end
                  end
               end
               ST_WACK:
               begin
                  state_q <= ST_WBYTE;
                  oe_q    <= 1'b0;
                  cnt_q   <= 4'h0;
               end
               ST_RBYTE:
               begin
                  if (byte_full)
                  begin
                     state_q <= ST_RACK;
                     oe_q    <= 1'b0;
                  end
                  else
                  begin
                     oe_q    <= ~shift_q[6];
                     shift_q <= {shift_q[6:0], 1'b0};
                     cnt_q   <= cnt_q + 4'h1;
                  end
               end
               default:
               begin
                  state_q <= ST_IDLE;
                  oe_q    <= 1'b0;
               end
            endcase
         end
      end
   end

   // open drain: only ever pull low
   assign sda_o     = 1'b0;
   assign sda_oe    = oe_q;
   assign reg_ptr   = ptr_q;
   assign reg_wr    = wr_q;
   assign reg_waddr = waddr_q;
   assign reg_wdata = wdata_q;

endmodule

`default_nettype wire

// *** dv/rail_meter_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module rail_meter_props #(
   parameter int RAILS = 4
) (
   // clock and reset
   input wire logic             mclk,
   input wire logic             rstn,
   // watched ports
   input wire logic             scl_i,
   input wire logic [RAILS-1:0] rail_good_raw,
   input wire logic [RAILS-1:0] rail_overcurrent_raw,
   input wire logic             meas_start,
   input wire logic [1:0]       meas_rail,
   input wire logic             meas_done,
   input wire logic             irq_n
);
   logic bus_q;
   logic cause_q;
   // ****
   // since reset: bus touched, event source seen
   // ****
   always_ff @(posedge mclk or negedge rstn)
      if (!rstn)
      begin
         bus_q   <= 1'b0;
         cause_q <= 1'b0;
      end
      else
      begin
         bus_q   <= bus_q | ~scl_i;
         cause_q <= cause_q | meas_done | (|rail_good_raw) | (|rail_overcurrent_raw);
      end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   // ****
   // properties
   // ****
   property p_start; meas_start |=> !meas_start; endproperty
   a_start: assert property (p_start) else $error("start too long");
   property p_rail; $changed(meas_rail) |-> meas_start; endproperty
   a_rail: assert property (p_rail) else $error("rail moved alone");
   property p_idle; $rose(rstn) |-> irq_n; endproperty
   a_idle: assert property (p_idle) else $error("irq at reset");
   // untouched masks keep every rail event silent; load ready resets unmasked
   property p_quiet; !bus_q |-> irq_n; endproperty
   a_quiet: assert property (p_quiet) else $error("irq masked");
   property p_cause; !irq_n |-> cause_q; endproperty
   a_cause: assert property (p_cause) else $error("irq no cause");
   property p_ready; meas_done |-> ##2 !irq_n; endproperty
   a_ready: assert property (p_ready) else $error("no ready irq");
   property p_fall; $fell(irq_n) |-> !scl_i || $past(meas_done, 2); endproperty
   a_fall: assert property (p_fall) else $error("irq fell oddly");
   property p_rise; $rose(irq_n) |-> !scl_i; endproperty
   a_rise: assert property (p_rise) else $error("irq rose alone");
   c_start: cover property (meas_start);
   c_ready: cover property (meas_done ##2 !irq_n);
   c_fall: cover property ($fell(irq_n) && !scl_i);
endmodule
bind rail_irq_mask_and_load_meter rail_meter_props #(.RAILS(RAILS)) props (
   .mclk, .rstn, .scl_i, .rail_good_raw, .rail_overcurrent_raw,
   .meas_start, .meas_rail, .meas_done, .irq_n
);
`default_nettype wire

// *** dv/host_serial_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module host_serial_model #(
   parameter logic [6:0] TARGET_ADDR = 7'h60
) (
   // clock
   input wire logic mclk,
   // serial pins, data 1 means released
   input wire logic sda_pin,
   output var logic scl_o,
   output var logic sda_h
);
   int nacks = 0;
   initial scl_o = 1'b1;
   initial sda_h = 1'b1;
   // ****
   // pin moves land 1 ns after an edge
   // ****
   task automatic hp(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic pins(input logic c, input logic d, input int n);
      scl_o = c;
      sda_h = d;
      hp(n);
   endtask
   task automatic start;
      pins(scl_o, 1'b1, 4);
      pins(1'b1, 1'b1, 8);
      pins(1'b1, 1'b0, 8);
      pins(1'b0, 1'b0, 4);
   endtask
   task automatic stop;
      pins(1'b0, 1'b0, 4);
      pins(1'b1, 1'b0, 8);
      pins(1'b1, 1'b1, 8);
   endtask
   // data moves only well inside the low phase, past the device's synchronisers
   task automatic bit_io(input logic b, output logic s);
      pins(1'b0, b, 8);
      pins(1'b1, b, 5);
      s = sda_pin;
      pins(1'b1, b, 5);
      pins(1'b0, b, 4);
   endtask
   task automatic byte_io(input logic [7:0] tx, input logic ack_due, output logic [7:0] rx);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(1'b1, s);
      if (ack_due && s !== 1'b0)
         nacks++;
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] x;
      start();
      byte_io({TARGET_ADDR, 1'b0}, 1'b1, x);
      byte_io(a, 1'b1, x);
      byte_io(d, 1'b1, x);
      stop();
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] x;
      start();
      byte_io({TARGET_ADDR, 1'b0}, 1'b1, x);
      byte_io(a, 1'b1, x);
      start();
      byte_io({TARGET_ADDR, 1'b1}, 1'b1, x);
      byte_io(8'hFF, 1'b0, d);
      stop();
   endtask
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic       mclk = 1'b0;
   logic       rstn = 1'b0;
   logic [3:0] rgood = 4'h0;
   logic [3:0] roc = 4'h0;
   logic       meas_done = 1'b0;
   logic [9:0] conv_val = 10'h000;
   logic [5:0] dly = 6'h00;
   logic [7:0] rv, ma, bm;
   logic [9:0] vals [4] = '{10'h3E8, 10'h001, 10'h2AA, 10'h155};
   wire        scl, host_sda, sda_o, sda_oe, meas_start, irq_n;
   wire  [1:0] meas_rail;
   wire        sda_pin = host_sda & (sda_oe ? sda_o : 1'b1);
   int         errors = 0;
   int         n_tests = 0;
   int         n_starts = 0;
   int         r, b;
   rail_irq_mask_and_load_meter dut (
      .mclk, .rstn, .scl_i(scl), .sda_i(sda_pin), .sda_o, .sda_oe,
      .rail_good_raw(rgood), .rail_overcurrent_raw(roc), .meas_start, .meas_rail,
      .meas_done, .meas_value(conv_val), .irq_n
   );
   host_serial_model host (.mclk, .sda_pin, .scl_o(scl), .sda_h(host_sda));
   always #4 mclk = ~mclk;
   // converter stand-in answers seven cycles after a start
   always @(posedge mclk)
   begin
      dly <= {dly[4:0], meas_start};
      meas_done <= dly[5];
      if (meas_start === 1'b1)
         n_starts++;
   end
   // ****
   // checks and bus calls
   // ****
   task automatic chk(input string what, input logic [9:0] e, input logic [9:0] g);
      n_tests++;
      if (g !== e)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      host.reg_read(a, rv);
      chk($sformatf("reg %h", a), {2'h0, e}, {2'h0, rv});
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host.reg_write(a, d);
   endtask
   task automatic ci(input logic e);
      chk("irq_n", {9'h000, e}, {9'h000, irq_n});
   endtask
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      repeat (90000) @(posedge mclk);
      errors++;
      report_and_stop();
   end
   initial
   begin
      repeat (12) @(posedge mclk);
      #1;
      rstn = 1'b1;
      host.hp(4);
      rgood = 4'hF;
      roc = 4'hF;
      host.hp(10);
      ci(1'b1);
      rgood = 4'h0;
      roc = 4'h0;
      host.hp(10);
      rdc(8'h1D, 8'h00);
      rdc(8'h19, 8'h55);
      rdc(8'h1A, 8'h55);
      wr(8'h19, 8'hFF);
      wr(8'h1A, 8'hFF);
      rdc(8'h19, 8'h00);
      rdc(8'h1A, 8'h00);
      rdc(8'h1E, 8'h00);
      rdc(8'h1F, 8'h55);
      rdc(8'h20, 8'h55);
      rdc(8'h21, 8'h00);
      rdc(8'h22, 8'h00);
      rdc(8'h23, 8'h00);
      wr(8'h20, 8'hFF);
      rdc(8'h20, 8'h55);
      // 10'h3E8 is a thousand steps of 20 mA, the full 20 A
      for (r = 0; r < 4; r++)
      begin
         conv_val = vals[r];
         wr(8'h21, {6'h3F, 2'(r)});
         chk("meas_rail", 10'(r), {8'h00, meas_rail});
         rdc(8'h21, {6'h00, 2'(r)});
         rdc(8'h18, 8'h01);
         ci(1'b0);
         rdc(8'h22, {6'h00, vals[r][9:8]});
         rdc(8'h23, vals[r][7:0]);
         wr(8'h18, 8'h01);
         ci(1'b1);
      end
      wr(8'h21, 8'h03);
      chk("starts", 10'h005, 10'(n_starts));
      wr(8'h18, 8'h01);
      rdc(8'h18, 8'h00);
      for (int i = 0; i < 6; i++)
      begin
         r = (i < 2) ? 0 : (i < 4) ? 2 : 3;
         b = (r % 2) * 4 + (i % 2) * 2;
         ma = (r < 2) ? 8'h1F : 8'h20;
         bm = 8'h01 << b;
         if (i % 2 == 1)
            rgood[r] = 1'b1;
         else
            roc[r] = 1'b1;
         host.hp(10);
         rdc(ma - 8'h03, bm);
         rdc(ma - 8'h06, bm);
         ci(1'b1);
         wr(ma, 8'h55 & ~bm);
         ci(1'b0);
         rdc(ma - 8'h03, bm);
         wr(ma - 8'h06, bm);
         ci(1'b1);
         rdc(ma - 8'h06, 8'h00);
         rgood = 4'h0;
         roc = 4'h0;
         wr(ma, 8'h55);
      end
      chk("acks", 10'h000, 10'(host.nacks));
      report_and_stop();
   end
endmodule
`default_nettype wire
